// File: src/spc_pkg.sv
// Package for the sleep and power controller: mode codes, states, timing.
// Assumes a single 50 MHz core clock.
package spc_pkg;
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;
    // Sleep mode select codes
    localparam logic [1:0] MODE_IDLE = 2'h0;
    localparam logic [1:0] MODE_ADC_NR = 2'h1;
    localparam logic [1:0] MODE_PWR_DOWN = 2'h2;
    localparam logic [1:0] MODE_PWR_SAVE = 2'h3;
    // Wake stall beyond start-up
    localparam int WAKE_STALL_CYC = 4;
    // Brown-out detector settle time on wake
    localparam int BOD_WAKE_US = 60;
    localparam int BOD_WAKE_CYC = BOD_WAKE_US * CLK_MHZ;
    // Timed sequence windows
    localparam int UNLOCK_WIN_CYC = 4;
    localparam int BROWNOUT_SLEEP_OFF_DELAY_CYC = 3;
    localparam int BROWNOUT_SLEEP_OFF_HOLD_CYC = 3;
    // Default start-up count for clock restart
    localparam int STARTUP_CYC_DEF = 16;
    localparam int PERIPH_N = 8;
    // Wake source bit positions
    localparam int WK_EXT_LEVEL = 0;
    localparam int WK_EXT_EDGE = 1;
    localparam int WK_PIN_CHG = 2;
    localparam int WK_MEM_RDY = 3;
    localparam int WK_ADC = 4;
    localparam int WK_WDT = 5;
    localparam int WK_SER_START = 6;
    localparam int WK_TIMER0 = 7;
    localparam int WK_OTHER_IO = 8;
    localparam int WK_N = 9;
    // Clock enable vector positions
    localparam int CK_CORE = 0;
    localparam int CK_FLASH = 1;
    localparam int CK_IO = 2;
    localparam int CK_CONV = 3;
    localparam int CK_ASYNC = 4;
    localparam int CK_OSC = 5;
    localparam int CK_N = 6;
    typedef enum logic [3:0] {
        ST_ACTIVE = 4'h1,
        ST_SLEEP = 4'h2,
        ST_STARTUP = 4'h4,
        ST_STALL = 4'h8
    } spc_state_t;
endpackage

// File: src/spc_timer.sv
// Down-counting delay timer with load and done flag.
// Assumes load is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ns
module spc_timer #(
    parameter int W = 16
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic load, // start a new count
    input wire logic [W-1:0] count, // cycles to wait
    output logic done // count reached zero
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    // Done must not look at load: the caller derives load from done
    assign done = (cnt_reg == '0);
endmodule // spc_timer

// File: src/spc_ctrl.sv
// Sleep mode and clock gating controller for a small microcontroller core.
// Assumes all control inputs come from core logic on core_clk; wake sources
// are already synchronised by their peripherals.
`timescale 1ns/1ns
module spc_ctrl
    import spc_pkg::*;
#(
    parameter int STARTUP_CYC = spc_pkg::STARTUP_CYC_DEF,
    parameter int BOD_CYC = spc_pkg::BOD_WAKE_CYC
) (
    input wire logic core_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic sleep_entry_permit, // sleep enable bit
    input wire logic [1:0] sleep_mode_select, // mode field
    input wire logic sleep_instr, // sleep instruction executed
    input wire logic core_control_wr, // write strobe of control reg
    input wire logic brownout_sleep_off_wd, // written sleep-off value
    input wire logic brownout_sleep_off_unlock_wd, // written unlock value
    input wire logic [spc_pkg::WK_N-1:0] wake_src, // enabled wake requests
    input wire logic timer0_async_select, // timer 0 on async clock
    input wire logic [1:0] timer0_irq_mask, // overflow, compare enables
    input wire logic global_irq_en, // global interrupt enable
    input wire logic sys_reset_req, // any reset source during sleep
    input wire logic adc_enabled, // converter is enabled
    input wire logic [spc_pkg::PERIPH_N-1:0] peripheral_clock_gate_reg, // gate bits
    output logic [spc_pkg::CK_N-1:0] clk_en, // domain clock enables
    output logic [spc_pkg::PERIPH_N-1:0] periph_clk_en, // per peripheral enables
    output logic [spc_pkg::PERIPH_N-1:0] periph_reg_access, // register access allowed
    output logic core_halt, // core stalled
    output logic wake_to_irq, // pulse: resume through handler
    output logic wake_to_reset, // pulse: restart at reset vector
    output logic adc_start, // pulse: auto conversion start
    output logic brownout_detector_en, // detector running
    output logic brownout_sleep_off, // sleep-off bit state
    output logic brownout_sleep_off_unlock, // unlock bit state
    output logic mem_retain // memories held during sleep
);
    import spc_pkg::*;

    spc_state_t state_reg;
    logic [1:0] mode_reg;
    logic bod_off_reg;
    logic via_reset_reg;
    logic [2:0] unlock_cnt_reg;
    logic [2:0] brownout_sleep_off_cnt_reg;
    logic brownout_sleep_off_active;
    logic wake_hit;
    logic go_sleep;
    logic tmr_load;
    logic [15:0] tmr_count;
    logic tmr_done;

    // Entry needs both conditions at once
    assign go_sleep = sleep_instr && sleep_entry_permit;

    // Sleep-off acts only during its window after three cycles
    assign brownout_sleep_off_active = brownout_sleep_off && (brownout_sleep_off_cnt_reg > 3'(BROWNOUT_SLEEP_OFF_DELAY_CYC));

    // Wake filter per mode
    always_comb begin
        wake_hit = 1'b0;
        unique case (mode_reg)
            MODE_IDLE: wake_hit = |wake_src;
            MODE_ADC_NR: wake_hit = wake_src[WK_ADC] | wake_src[WK_WDT] |
                wake_src[WK_SER_START] | wake_src[WK_TIMER0] |
                wake_src[WK_MEM_RDY] | wake_src[WK_EXT_LEVEL] |
                wake_src[WK_PIN_CHG];
            MODE_PWR_DOWN: wake_hit = wake_src[WK_WDT] | wake_src[WK_SER_START] |
                wake_src[WK_EXT_LEVEL] | wake_src[WK_PIN_CHG];
            MODE_PWR_SAVE: wake_hit = wake_src[WK_WDT] | wake_src[WK_SER_START] |
                wake_src[WK_EXT_LEVEL] | wake_src[WK_PIN_CHG] |
                (wake_src[WK_TIMER0] && timer0_async_select && global_irq_en &&
                 (|timer0_irq_mask));
        endcase
    end

    // Start-up length: fused period for deep modes, longer if detector was off
    // Loaded one short: the state holds one cycle more while done shows
    always_comb begin
        tmr_count = 16'(WAKE_STALL_CYC - 1);
        if (state_reg == ST_SLEEP) begin
            if (bod_off_reg && (BOD_CYC > STARTUP_CYC)) begin
                tmr_count = 16'(BOD_CYC - 1);
            end else if (mode_reg[1]) begin
                tmr_count = 16'(STARTUP_CYC - 1);
            end else begin
                tmr_count = 16'h0000;
            end
        end
    end
    assign tmr_load = (state_reg == ST_SLEEP && wake_hit && !sys_reset_req) ||
        (state_reg == ST_STARTUP && tmr_done);

    spc_timer #(
        .W(16)
    ) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(tmr_load),
        .count(tmr_count),
        .done(tmr_done)
    );

    // Main sequence
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_ACTIVE;
            mode_reg <= MODE_IDLE;
            bod_off_reg <= 1'b0;
            via_reset_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_ACTIVE: begin
                    if (go_sleep) begin
                        state_reg <= ST_SLEEP;
                        mode_reg <= sleep_mode_select;
                        bod_off_reg <= brownout_sleep_off_active && sleep_mode_select[1];
                        via_reset_reg <= 1'b0;
                    end
                end
                ST_SLEEP: begin
                    if (sys_reset_req) begin
                        state_reg <= ST_ACTIVE;
                        via_reset_reg <= 1'b1;
                        bod_off_reg <= 1'b0;
                    end else if (wake_hit) begin
                        state_reg <= ST_STARTUP;
                        bod_off_reg <= 1'b0;
                    end
                end
                ST_STARTUP: begin
                    if (tmr_done) begin
                        state_reg <= ST_STALL;
                    end
                end
                ST_STALL: begin
                    if (tmr_done) begin
                        state_reg <= ST_ACTIVE;
                    end
                end
                default: state_reg <= ST_ACTIVE;
            endcase
        end
    end

    // Outputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_en <= '1;
            periph_clk_en <= '1;
            periph_reg_access <= '1;
            core_halt <= 1'b0;
            wake_to_irq <= 1'b0;
            wake_to_reset <= 1'b0;
            adc_start <= 1'b0;
            brownout_detector_en <= 1'b1;
            mem_retain <= 1'b0;
        end else begin
            wake_to_irq <= state_reg == ST_STALL && tmr_done;
            wake_to_reset <= state_reg == ST_SLEEP && sys_reset_req;
            adc_start <= state_reg == ST_ACTIVE && go_sleep && adc_enabled &&
                !sleep_mode_select[1];
            core_halt <= state_reg != ST_ACTIVE && !(state_reg == ST_STALL && tmr_done);
            mem_retain <= state_reg != ST_ACTIVE;
            brownout_detector_en <= !(state_reg == ST_SLEEP && bod_off_reg &&
                !wake_hit && !sys_reset_req);
            if (state_reg == ST_SLEEP && !wake_hit && !sys_reset_req) begin
                clk_en[CK_CORE] <= 1'b0;
                clk_en[CK_FLASH] <= 1'b0;
                clk_en[CK_IO] <= mode_reg == MODE_IDLE;
                clk_en[CK_CONV] <= !mode_reg[1];
                clk_en[CK_ASYNC] <= mode_reg != MODE_PWR_DOWN;
                clk_en[CK_OSC] <= !mode_reg[1];
                periph_clk_en <= mode_reg == MODE_IDLE ? ~peripheral_clock_gate_reg
                    : '0;
            end else begin
                clk_en <= '1;
                periph_clk_en <= ~peripheral_clock_gate_reg;
            end
            periph_reg_access <= ~peripheral_clock_gate_reg;
        end
    end

    // Unlock window and sleep-off bit timing
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            brownout_sleep_off_unlock <= 1'b0;
            unlock_cnt_reg <= 3'h0;
        end else if (core_control_wr && brownout_sleep_off_wd &&
                     brownout_sleep_off_unlock_wd) begin
            brownout_sleep_off_unlock <= 1'b1;
            unlock_cnt_reg <= 3'(UNLOCK_WIN_CYC);
        end else if (unlock_cnt_reg != 3'h0) begin
            unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
            if (unlock_cnt_reg == 3'h1) begin
                brownout_sleep_off_unlock <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            brownout_sleep_off <= 1'b0;
            brownout_sleep_off_cnt_reg <= 3'h0;
        end else if (core_control_wr && brownout_sleep_off_wd &&
                     !brownout_sleep_off_unlock_wd && brownout_sleep_off_unlock) begin
            brownout_sleep_off <= 1'b1;
            brownout_sleep_off_cnt_reg <= 3'h1;
        end else if (brownout_sleep_off) begin
            if (brownout_sleep_off_cnt_reg == 3'(BROWNOUT_SLEEP_OFF_DELAY_CYC + BROWNOUT_SLEEP_OFF_HOLD_CYC)) begin
                brownout_sleep_off <= 1'b0;
                brownout_sleep_off_cnt_reg <= 3'h0;
            end else begin
                brownout_sleep_off_cnt_reg <= brownout_sleep_off_cnt_reg + 3'h1;
            end
        end
    end

    property p_sleep_entry;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE && !go_sleep) |=> state_reg != ST_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("sleep without permit");

    property p_idle_clocks;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && mode_reg == MODE_IDLE && !wake_hit && !sys_reset_req)
        |=> !clk_en[CK_CORE] && clk_en[CK_IO] && clk_en[CK_CONV];
    endproperty
    a_idle_clocks: assert property (p_idle_clocks) else $error("idle clock set wrong");

    property p_adcnr_io;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && mode_reg == MODE_ADC_NR && !wake_hit && !sys_reset_req)
        |=> !clk_en[CK_IO] && clk_en[CK_CONV];
    endproperty
    a_adcnr_io: assert property (p_adcnr_io) else $error("adc nr clocks wrong");

    property p_edge_blocked;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && mode_reg != MODE_IDLE && wake_src == WK_N'(1 << WK_EXT_EDGE)
         && !sys_reset_req) |=> state_reg == ST_SLEEP;
    endproperty
    a_edge_blocked: assert property (p_edge_blocked) else $error("edge woke deep sleep");

    property p_reset_wake;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_SLEEP && sys_reset_req) |=> wake_to_reset && state_reg == ST_ACTIVE;
    endproperty
    a_reset_wake: assert property (p_reset_wake) else $error("reset did not wake");

    property p_stall_four;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_STARTUP && tmr_done) |=> (state_reg == ST_STALL) [*4] ##1
            (state_reg == ST_ACTIVE && wake_to_irq);
    endproperty
    a_stall_four: assert property (p_stall_four) else $error("stall not four cycles");

    property p_brownout_sleep_off_clear;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(brownout_sleep_off) |-> brownout_sleep_off [*6] ##1 !brownout_sleep_off;
    endproperty
    a_brownout_sleep_off_clear: assert property (p_brownout_sleep_off_clear) else $error("sleep-off timing wrong");

    property p_unlock_needed;
        @(posedge core_clk) disable iff (!rst_n)
        (!brownout_sleep_off && !brownout_sleep_off_unlock) |=> !brownout_sleep_off;
    endproperty
    a_unlock_needed: assert property (p_unlock_needed) else $error("sleep-off set unlocked");

    property p_gate;
        @(posedge core_clk) disable iff (!rst_n)
        (state_reg == ST_ACTIVE && !go_sleep) |=> periph_clk_en == ~$past(peripheral_clock_gate_reg);
    endproperty
    a_gate: assert property (p_gate) else $error("gate not applied");

endmodule // spc_ctrl

// File: tb/spc_wake_model.sv
// Wake source model: peripherals raising interrupt flags toward the controller.
// Assumes a flag drops only once the core is woken, as real sources behave.
`timescale 1ns/1ns
module spc_wake_model
    import spc_pkg::*;
(
    input wire logic core_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [spc_pkg::WK_N-1:0] fire, // pulse: raise a flag
    input wire logic wake_to_irq, // handler entered
    input wire logic wake_to_reset, // core restarted
    output logic [spc_pkg::WK_N-1:0] wake_src // pending flags
);
    // A refused source stays pending, so a later wake must not be masked by it
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_src <= '0;
        end else if (wake_to_irq || wake_to_reset) begin
            wake_src <= '0;
        end else begin
            wake_src <= wake_src | fire;
        end
    end
endmodule // spc_wake_model

// File: tb/tb.sv
// Testbench for the sleep controller: sleep entry, wake filtering, brown-out, gating.
// Assumes spc_ctrl and the wake source model; start-up counts are shortened.
`timescale 1ns/1ns
module tb;
    import spc_pkg::*;
    localparam int SU = 8;
    localparam int BC = 40;
    localparam logic [1:0] MD [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    localparam logic [8:0] MSK [5] = '{9'h1FF, 9'h0FD, 9'h065, 9'h0E5, 9'h065};
    localparam logic [5:0] CK [5] = '{6'h3C, 6'h38, 6'h00, 6'h10, 6'h10};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep_entry_permit = 1'b1;
    logic [1:0] sleep_mode_select = 2'h0;
    logic sleep_instr = 1'b0;
    logic core_control_wr = 1'b0;
    logic bso_wd = 1'b0;
    logic bsu_wd = 1'b0;
    logic timer0_async_select = 1'b1;
    logic [1:0] timer0_irq_mask = 2'h3;
    logic global_irq_en = 1'b1;
    logic sys_reset_req = 1'b0;
    logic adc_enabled = 1'b1;
    logic [7:0] gate = 8'h00;
    logic [8:0] fire = 9'h000;
    logic [8:0] wake_src;
    logic [5:0] clk_en;
    logic [7:0] periph_clk_en, periph_reg_access;
    logic core_halt, wake_to_irq, wake_to_reset, adc_start, brownout_detector_en;
    logic brownout_sleep_off, brownout_sleep_off_unlock, mem_retain, a, rs;
    int errors = 0;
    int tests_run = 0;
    int n;
    int lo;

    always #10 core_clk = ~core_clk;

    spc_ctrl #(.STARTUP_CYC(SU), .BOD_CYC(BC)) spc_ctrl_i (.core_clk(core_clk),
        .rst_n(rst_n), .sleep_entry_permit(sleep_entry_permit),
        .sleep_mode_select(sleep_mode_select), .sleep_instr(sleep_instr),
        .core_control_wr(core_control_wr), .brownout_sleep_off_wd(bso_wd),
        .brownout_sleep_off_unlock_wd(bsu_wd), .wake_src(wake_src),
        .timer0_async_select(timer0_async_select), .timer0_irq_mask(timer0_irq_mask),
        .global_irq_en(global_irq_en), .sys_reset_req(sys_reset_req),
        .adc_enabled(adc_enabled), .peripheral_clock_gate_reg(gate), .clk_en(clk_en),
        .periph_clk_en(periph_clk_en), .periph_reg_access(periph_reg_access),
        .core_halt(core_halt), .wake_to_irq(wake_to_irq), .wake_to_reset(wake_to_reset),
        .adc_start(adc_start), .brownout_detector_en(brownout_detector_en),
        .brownout_sleep_off(brownout_sleep_off),
        .brownout_sleep_off_unlock(brownout_sleep_off_unlock), .mem_retain(mem_retain));

    spc_wake_model spc_wake_model_i (.core_clk(core_clk), .rst_n(rst_n), .fire(fire),
        .wake_to_irq(wake_to_irq), .wake_to_reset(wake_to_reset), .wake_src(wake_src));

    task automatic step;
        @(posedge core_clk);
        #1;
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            errors++;
            $display("ERROR t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic s, input logic u);
        core_control_wr = 1'b1;
        bso_wd = s;
        bsu_wd = u;
        step();
        core_control_wr = 1'b0;
    endtask

    // Adc pulse may land on any of the first few cycles after entry
    task automatic enter(input logic [1:0] m, output logic seen);
        sleep_mode_select = m;
        sleep_instr = 1'b1;
        step();
        sleep_instr = 1'b0;
        seen = 1'b0;
        repeat (4) begin
            if (adc_start === 1'b1) seen = 1'b1;
            step();
        end
    endtask

    // Returns cycles from the request to the resume or reset pulse
    task automatic wake(input logic [8:0] src, output int c, output logic to_rst);
        fire = src;
        step();
        fire = 9'h000;
        c = 1;
        while (wake_to_irq !== 1'b1 && wake_to_reset !== 1'b1) begin
            if (c > 400) begin
                chk(9'h000, 9'h001);
                test_done();
            end
            step();
            c++;
        end
        to_rst = wake_to_reset;
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        #1 rst_n = 1'b1;
        chk(clk_en, 9'h03F);
        chk(brownout_sleep_off, 9'h000);
        chk(periph_clk_en, 9'h0FF);
        sleep_entry_permit = 1'b0;
        enter(2'h2, a);
        chk(core_halt, 9'h000);
        sleep_entry_permit = 1'b1;
        $display("test permit done");
        for (int r = 0; r < 5; r++) begin
            global_irq_en = (r != 4);
            for (int b = 0; b < WK_N; b++) begin
                enter(MD[r], a);
                chk(clk_en, CK[r]);
                chk(core_halt, 9'h001);
                chk(mem_retain, 9'h001);
                chk(brownout_detector_en, 9'h001);
                chk(a, (MD[r] < 2'h2) ? 9'h001 : 9'h000);
                if (MSK[r][b]) begin
                    // Shallow modes keep the oscillator, so no fused start-up
                    lo = MD[r][1] ? SU : 0;
                    wake(9'h001 << b, n, rs);
                    chk_rng(n, lo + WAKE_STALL_CYC, lo + WAKE_STALL_CYC + 4);
                end else begin
                    fire = 9'h001 << b;
                    step();
                    fire = 9'h000;
                    repeat (20) step();
                    chk(core_halt, 9'h001);
                    wake(9'h020, n, rs);
                end
                chk(rs, 9'h000);
                step();
                chk(core_halt, 9'h000);
                chk(clk_en, 9'h03F);
            end
        end
        $display("test modes done");
        adc_enabled = 1'b0;
        gate = 8'hA5;
        repeat (2) step();
        chk(periph_clk_en, 9'h05A);
        chk(periph_reg_access, 9'h05A);
        enter(2'h0, a);
        chk(periph_clk_en, 9'h05A);
        chk(a, 9'h000);
        wake(9'h020, n, rs);
        gate = 8'h00;
        repeat (2) step();
        chk(periph_clk_en, 9'h0FF);
        chk(periph_reg_access, 9'h0FF);
        $display("test gating done");
        enter(2'h2, a);
        sys_reset_req = 1'b1;
        wake(9'h000, n, rs);
        chk(rs, 9'h001);
        chk_rng(n, 1, 3);
        sys_reset_req = 1'b0;
        repeat (3) step();
        $display("test reset done");
        wr(1'b1, 1'b0);
        repeat (2) step();
        chk(brownout_sleep_off, 9'h000);
        wr(1'b1, 1'b1);
        repeat (6) step();
        wr(1'b1, 1'b0);
        repeat (2) step();
        chk(brownout_sleep_off, 9'h000);
        wr(1'b1, 1'b1);
        step();
        chk(brownout_sleep_off_unlock, 9'h001);
        wr(1'b1, 1'b0);
        repeat (10) step();
        chk(brownout_sleep_off, 9'h000);
        wr(1'b1, 1'b1);
        step();
        wr(1'b1, 1'b0);
        step();
        chk(brownout_sleep_off, 9'h001);
        repeat (2) step();
        enter(2'h2, a);
        chk(brownout_detector_en, 9'h000);
        wake(9'h020, n, rs);
        chk_rng(n, BC, BC + SU + WAKE_STALL_CYC + 8);
        step();
        chk(brownout_detector_en, 9'h001);
        $display("test brownout done");
        test_done();
    end
endmodule // tb
